// ==== hw/irq_ctrl_pkg.sv ====
/*
  constants, register map, source map and sequencer states of the
  interrupt controller of the 8-bit core.
  assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package irq_ctrl_pkg;
    localparam int PC_W = 13;
    localparam int NUM_SRC = 13;
    localparam int IDX_W = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_CTRL3 = 8'h0C;
    localparam logic [7:0] OFS_EDGE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int NUM_REG = 6;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // field positions
    localparam int GIE_BIT = 0;
    localparam int EDGE_A_LSB = 0;
    localparam int EDGE_B_LSB = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_IDX_LSB = 4;
    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;
    // source index = priority = vector order:
    // 0 pin a, 1 pin b, 2 serial module, 3 low supply, 4 adc, 5 eeprom,
    // 6 time base a, 7 per timer p, 8 per timer a, 9 std timer p,
    // 10 std timer a, 11 serial port, 12 time base b
    localparam int SRC_PIN_A = 0;
    localparam int SRC_PIN_B = 1;
    localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3};
    localparam int SRC_FBIT [NUM_SRC] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 5, 4};
    localparam int SRC_EBIT [NUM_SRC] = '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3, 1, 0};
    // vector table base and spacing
    localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
    localparam logic [PC_W-1:0] VEC_STEP = 13'h0004;
    // sequencer states, gray along idle-push and idle-pop
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_POP = 2'b10
    } seq_state_t;
endpackage

// ==== hw/ext_pin_edge.sv ====
/*
  synchroniser, filter and edge detector of one external interrupt pin.
  assumes an asynchronous pin level and the system clock domain.
*/
`timescale 1ns/1ps
module ext_pin_edge
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pinIn,
    input wire logic [1:0] edgeSel,
    input wire logic pinActive,
    output logic edgePulse
);
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;
    logic pulse_q;
    wire agree = (sync2_q == sync3_q);
    wire levelNew = agree ? sync2_q : level_q;
    wire rose = levelNew & ~level_q;
    wire fell = ~levelNew & level_q;
    // edge type decode
    wire hitRise = rose & ((edgeSel == EDGE_RISE) | (edgeSel == EDGE_BOTH));
    wire hitFall = fell & ((edgeSel == EDGE_FALL) | (edgeSel == EDGE_BOTH));
    wire hit = pinActive & (hitRise | hitFall);

    // three-stage chain, level accepted when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            level_q <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= levelNew;
            pulse_q <= hit;
        end
    end

    assign edgePulse = pulse_q;

    // disabled field never yields an edge
    chk_edge_disabled: assert property (@(posedge clk) disable iff (!rstn)
        (edgeSel == EDGE_OFF) |=> !edgePulse || ($past(edgeSel) != EDGE_OFF))
        else $error("edge reported with edge field disabled");
endmodule

// ==== hw/mcu_interrupt_controller.sv ====
/*
  interrupt controller: request flags, enables, global enable,
  priority selection, push/vector/pop sequencing and wake-up.
  assumes the core raises instrBoundary when an interrupt may enter,
  offers the top of its stack on popData while popStack is high,
  and reports stackFull; registers are reached over APB.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mcu_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins and their routing
    input wire logic pinA,
    input wire logic pinB,
    input wire logic pinAShareSel,
    input wire logic pinBShareSel,
    input wire logic pinADirIn,
    input wire logic pinBDirIn,
    input wire logic pinAPullSel,
    input wire logic pinBPullSel,
    output logic pinAPullEn,
    output logic pinBPullEn,
    // internal event pulses, indices 2 to 12
    input wire logic serialModuleEvt,
    input wire logic lowSupplyEvt,
    input wire logic adcDoneEvt,
    input wire logic eepromDoneEvt,
    input wire logic timeBaseAEvt,
    input wire logic perTimerPEvt,
    input wire logic perTimerAEvt,
    input wire logic stdTimerPEvt,
    input wire logic stdTimerAEvt,
    input wire logic serialPortEvt,
    input wire logic timeBaseBEvt,
    // core side
    input wire logic instrBoundary,
    input wire logic stackFull,
    input wire logic [PC_W-1:0] pcNext,
    input wire logic retiExec,
    input wire logic [PC_W-1:0] popData,
    input wire logic lowPower,
    output logic irqReq,
    output logic pushStack,
    output logic [PC_W-1:0] pushData,
    output logic popStack,
    output logic pcLoad,
    output logic [PC_W-1:0] pcLoadValue,
    output logic wakeUp
);
    logic [NUM_SRC-1:0] flags_q;
    logic [NUM_SRC-1:0] flags_d;
    logic [NUM_SRC-1:0] enables_q;
    logic [NUM_SRC-1:0] enables_d;
    logic gie_q;
    logic gie_d;
    logic [3:0] edgeCfg_q;
    seq_state_t state_q;
    seq_state_t state_d;
    logic [IDX_W-1:0] takeIdx_q;
    logic [PC_W-1:0] pushData_q;
    logic [PC_W-1:0] pcLoadValue_q;
    logic pushStack_q;
    logic popStack_q;
    logic pcLoad_q;
    logic wakeUp_q;
    logic pullA_q;
    logic pullB_q;
    logic [31:0] prdata_q;
    logic [7:0] rdByte [NUM_REG];
    logic [IDX_W-1:0] takeIdx;
    logic edgeA;
    logic edgeB;

    // vector address of a source, one distinct slot each
    function automatic logic [PC_W-1:0] vecAddr(input logic [IDX_W-1:0] idx);
        vecAddr = VEC_BASE + ({{(PC_W-IDX_W){1'b0}}, idx} * VEC_STEP);
    endfunction

    // lowest pending index wins
    function automatic logic [IDX_W-1:0] pickLowest(input logic [NUM_SRC-1:0] req);
        pickLowest = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                pickLowest = IDX_W'(i);
            end
        end
    endfunction

    // apb decode
    wire [5:0] regIdx = paddr[7:2];
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
    wire access = psel & penable;
    wire setup = psel & ~penable;
    wire wrNow = access & pwrite & mapped;
    wire wrCtrl0 = wrNow & (paddr == OFS_CTRL0);
    wire wrEdge = wrNow & (paddr == OFS_EDGE);
    wire [3:0] wrCtrl = {wrNow & (paddr == OFS_CTRL3), wrNow & (paddr == OFS_CTRL2),
                         wrNow & (paddr == OFS_CTRL1), wrCtrl0};
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    // external pins: active only when routed to interrupt and set as input
    wire pinAActive = pinAShareSel & pinADirIn;
    wire pinBActive = pinBShareSel & pinBDirIn;

    ext_pin_edge pinAEdge (
        .clk(clk),
        .rstn(rstn),
        .pinIn(pinA),
        .edgeSel(edgeCfg_q[EDGE_A_LSB +: 2]),
        .pinActive(pinAActive),
        .edgePulse(edgeA)
    );

    ext_pin_edge pinBEdge (
        .clk(clk),
        .rstn(rstn),
        .pinIn(pinB),
        .edgeSel(edgeCfg_q[EDGE_B_LSB +: 2]),
        .pinActive(pinBActive),
        .edgePulse(edgeB)
    );

    // event vector in source order
    wire [NUM_SRC-1:0] evtSet = {timeBaseBEvt, serialPortEvt, stdTimerAEvt, stdTimerPEvt,
                                 perTimerAEvt, perTimerPEvt, timeBaseAEvt, eepromDoneEvt,
                                 adcDoneEvt, lowSupplyEvt, serialModuleEvt, edgeB, edgeA};

    // request selection
    wire [NUM_SRC-1:0] pendingEn = flags_q & enables_q;
    wire canTake = gie_q & ~stackFull & (state_q == ST_IDLE) & ~pcLoad_q;
    assign takeIdx = pickLowest(pendingEn);
    assign irqReq = canTake & (|pendingEn);
    wire takeNow = irqReq & instrBoundary;
    wire retiNow = retiExec & (state_q == ST_IDLE) & ~pcLoad_q & ~takeNow;
    wire [NUM_SRC-1:0] takeMask = takeNow ? (NUM_SRC'(1) << takeIdx) : '0;
    wire [NUM_SRC-1:0] lowerMask = (NUM_SRC'(1) << takeIdx) - NUM_SRC'(1);

    // per-source flag and enable next values
    generate
        for (genvar i = 0; i < NUM_SRC; i++)
        begin : gSrc
            wire wrHit = wrCtrl[SRC_REG[i]];
            wire flagSw = wrHit ? pwdata[SRC_FBIT[i]] : flags_q[i];
            // service clears, a fresh event still wins
            assign flags_d[i] = (flagSw & ~takeMask[i]) | evtSet[i];
            assign enables_d[i] = wrHit ? pwdata[SRC_EBIT[i]] : enables_q[i];
        end
    endgenerate

    // global enable: software may set it again inside a routine
    assign gie_d = takeNow ? 1'b0 : (wrCtrl0 ? pwdata[GIE_BIT] : gie_q);

    // sequencer next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (takeNow)
                begin
                    state_d = ST_PUSH;
                end
                else if (retiNow)
                begin
                    state_d = ST_POP;
                end
            end
            ST_PUSH: state_d = ST_IDLE;
            ST_POP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // register readback
    always_comb
    begin
        for (int r = 0; r < NUM_REG; r++)
        begin
            rdByte[r] = RESET_VAL;
        end
        for (int i = 0; i < NUM_SRC; i++)
        begin
            rdByte[SRC_REG[i]][SRC_FBIT[i]] = flags_q[i];
            rdByte[SRC_REG[i]][SRC_EBIT[i]] = enables_q[i];
        end
        rdByte[0][GIE_BIT] = gie_q;
        rdByte[4][3:0] = edgeCfg_q;
        rdByte[5][STAT_BUSY_BIT] = (state_q != ST_IDLE);
        rdByte[5][STAT_FULL_BIT] = stackFull;
        rdByte[5][STAT_IDX_LSB +: IDX_W] = takeIdx_q;
    end

    wire [31:0] rdWord = mapped ? {24'h000000, rdByte[regIdx[2:0]]} : 32'h00000000;

    // control state
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            flags_q <= '0;
            enables_q <= '0;
            gie_q <= 1'b0;
            edgeCfg_q <= 4'h0;
            state_q <= ST_IDLE;
        end
        else
        begin
            flags_q <= flags_d;
            enables_q <= enables_d;
            gie_q <= gie_d;
            edgeCfg_q <= wrEdge ? pwdata[3:0] : edgeCfg_q;
            state_q <= state_d;
        end
    end

    // push, vector load and pop pulses
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            takeIdx_q <= '0;
            pushData_q <= '0;
            pcLoadValue_q <= '0;
            pushStack_q <= 1'b0;
            popStack_q <= 1'b0;
            pcLoad_q <= 1'b0;
        end
        else
        begin
            pushStack_q <= takeNow;
            popStack_q <= retiNow;
            pcLoad_q <= (state_q == ST_PUSH) | (state_q == ST_POP);
            if (takeNow)
            begin
                takeIdx_q <= takeIdx;
                pushData_q <= pcNext;
            end
            if (state_q == ST_PUSH)
            begin
                pcLoadValue_q <= vecAddr(takeIdx_q);
            end
            else if (state_q == ST_POP)
            begin
                pcLoadValue_q <= popData;
            end
        end
    end

    // wake, pull-high and read data
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wakeUp_q <= 1'b0;
            pullA_q <= 1'b0;
            pullB_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            wakeUp_q <= lowPower & (|(evtSet & ~flags_q));
            pullA_q <= pinAPullSel;
            pullB_q <= pinBPullSel;
            prdata_q <= setup ? rdWord : prdata_q;
        end
    end

    assign pushStack = pushStack_q;
    assign pushData = pushData_q;
    assign popStack = popStack_q;
    assign pcLoad = pcLoad_q;
    assign pcLoadValue = pcLoadValue_q;
    assign wakeUp = wakeUp_q;
    assign pinAPullEn = pullA_q;
    assign pinBPullEn = pullB_q;

    // events always latch
    chk_flag_latch: assert property (@(posedge clk) disable iff (!rstn)
        (evtSet != '0) |=> ((flags_q & $past(evtSet)) == $past(evtSet)))
        else $error("event did not set its flag");

    chk_take_enabled: assert property (@(posedge clk) disable iff (!rstn)
        takeNow |-> (flags_q[takeIdx] && enables_q[takeIdx]))
        else $error("interrupt taken from a disabled source");

    chk_gie_blocks: assert property (@(posedge clk) disable iff (!rstn)
        !gie_q |=> !pushStack)
        else $error("interrupt entered with global enable low");

    chk_push_load: assert property (@(posedge clk) disable iff (!rstn)
        takeNow |=> (pushStack && pushData == $past(pcNext)) ##1
        (pcLoad && !pushStack && pcLoadValue == vecAddr($past(takeIdx, 2))))
        else $error("push then vector load out of sequence");

    chk_return_from_irq_instr_pop: assert property (@(posedge clk) disable iff (!rstn)
        retiNow |=> popStack ##1 (pcLoad && pcLoadValue == $past(popData)))
        else $error("return did not restore popped pc");

    chk_gie_cleared: assert property (@(posedge clk) disable iff (!rstn)
        takeNow |=> !gie_q ##1 (!irqReq || $past(wrCtrl0)))
        else $error("global enable not cleared on service");

    chk_stack_full: assert property (@(posedge clk) disable iff (!rstn)
        stackFull |=> !pushStack)
        else $error("interrupt taken with stack full");

    chk_wake_new: assert property (@(posedge clk) disable iff (!rstn)
        (lowPower && (evtSet & ~flags_q) != '0) |=> wakeUp)
        else $error("newly set flag did not wake");

    chk_wake_cause: assert property (@(posedge clk) disable iff (!rstn)
        wakeUp |-> $past(lowPower) && ($past(evtSet) & ~$past(flags_q)) != '0)
        else $error("wake without a new flag");

    chk_flag_cleared: assert property (@(posedge clk) disable iff (!rstn)
        (takeNow && !evtSet[takeIdx] && !wrCtrl[SRC_REG[takeIdx]])
        |=> !flags_q[$past(takeIdx)])
        else $error("serviced flag not cleared");

    chk_priority: assert property (@(posedge clk) disable iff (!rstn)
        takeNow |-> ((pendingEn & lowerMask) == '0))
        else $error("lower vector pending was skipped");
endmodule

// ==== verif/core_stack_model.sv ====
/*
  model of the core: return stack and fetch address.
  assumes one push or pop per cycle from the controller.
*/
`timescale 1ns/1ps
module core_stack_model
    import irq_ctrl_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pushStack,
    input wire logic [PC_W-1:0] pushData,
    input wire logic popStack,
    input wire logic pcLoad,
    input wire logic [PC_W-1:0] pcLoadValue,
    output logic stackFull,
    output logic [PC_W-1:0] pcNext,
    output logic [PC_W-1:0] popData
);
    logic [PC_W-1:0] stack_q [DEPTH];
    int sp_q;
    logic [PC_W-1:0] pc_q;
    // top of stack only while popping; a moving pattern otherwise
    assign popData = (popStack && sp_q > 0) ? stack_q[sp_q-1] : ~pc_q;
    assign stackFull = (sp_q == DEPTH);
    assign pcNext = pc_q;
    // stack pointer, stack and a free-running fetch address
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sp_q <= 0;
            pc_q <= 13'h0100;
        end
        else
        begin
            pc_q <= pcLoad ? pcLoadValue : pc_q + 13'h0001;
            if (pushStack && sp_q < DEPTH)
            begin
                stack_q[sp_q] <= pushData;
                sp_q <= sp_q + 1;
            end
            else if (popStack && sp_q > 0)
                sp_q <= sp_q - 1;
        end
    end
endmodule

// ==== verif/mcu_interrupt_controller_tb.sv ====
/*
  self-checking bench: apb register access, event sources, pins,
  entry, return and nesting against a two-deep core stack model.
  assumes zero-wait apb slave and registered core-side pulses.
*/
`timescale 1ns/1ps
module mcu_interrupt_controller_tb
    import irq_ctrl_pkg::*;
;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, lastErr, pinAPullEn, pinBPullEn;
    logic pinA = 0, pinB = 0, pinAShareSel = 1, pinBShareSel = 1;
    logic pinADirIn = 1, pinBDirIn = 1, pinAPullSel = 0, pinBPullSel = 0;
    logic [NUM_SRC-1:0] evts = 13'h0000;
    logic instrBoundary = 0, retiExec = 0, lowPower = 0, stackFull, irqReq;
    logic pushStack, popStack, pcLoad, wakeUp;
    logic [PC_W-1:0] pcNext, popData, pushData, pcLoadValue, tkPc, lastPush;
    logic [7:0] ra, fb, eb;
    logic [7:0] adrList [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_CTRL2, OFS_CTRL3, OFS_EDGE, OFS_STATUS};
    logic [7:0] maskList [5] = '{8'h7F, 8'hFF, 8'hFF, 8'h33, 8'h0F};
    int errors = 0, tests_run = 0;

    mcu_interrupt_controller mcu_interrupt_controller_i (.clk(clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinA(pinA), .pinB(pinB),
        .pinAShareSel(pinAShareSel), .pinBShareSel(pinBShareSel), .pinADirIn(pinADirIn),
        .pinBDirIn(pinBDirIn), .pinAPullSel(pinAPullSel), .pinBPullSel(pinBPullSel),
        .pinAPullEn(pinAPullEn), .pinBPullEn(pinBPullEn), .serialModuleEvt(evts[2]),
        .lowSupplyEvt(evts[3]), .adcDoneEvt(evts[4]), .eepromDoneEvt(evts[5]),
        .timeBaseAEvt(evts[6]), .perTimerPEvt(evts[7]), .perTimerAEvt(evts[8]),
        .stdTimerPEvt(evts[9]), .stdTimerAEvt(evts[10]), .serialPortEvt(evts[11]),
        .timeBaseBEvt(evts[12]), .instrBoundary(instrBoundary), .stackFull(stackFull),
        .pcNext(pcNext), .retiExec(retiExec), .popData(popData), .lowPower(lowPower),
        .irqReq(irqReq), .pushStack(pushStack), .pushData(pushData), .popStack(popStack),
        .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .wakeUp(wakeUp));

    core_stack_model #(.DEPTH(2)) core_stack_model_i (.clk(clk), .rstn(rstn),
        .pushStack(pushStack), .pushData(pushData), .popStack(popStack), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .stackFull(stackFull), .pcNext(pcNext), .popData(popData));

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            errors++;
            wrap_up();
        end
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    // wait for a pc load and compare its value, read as it stood before the edge
    task automatic waitPc(input logic [PC_W-1:0] exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pcLoad !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            errors++;
            wrap_up();
        end
        chk({19'h0, pcLoadValue}, {19'h0, exp});
    endtask

    task automatic noTake(input int cycles);
        int seen;
        seen = 0;
        repeat (cycles)
        begin
            @(posedge clk);
            if (pcLoad !== 1'b0)
                seen++;
        end
        chk(32'(seen), 32'h0);
    endtask

    // one-cycle event, wake pulse checked one cycle later
    task automatic pulse(input int i, input logic expW);
        @(posedge clk);
        evts[i] <= 1'b1;
        @(posedge clk);
        evts[i] <= 1'b0;
        @(posedge clk);
        chk({31'h0, wakeUp}, {31'h0, expW});
    endtask

    task automatic pin(input logic a, input logic b);
        @(posedge clk);
        pinA <= a;
        pinB <= b;
        repeat (8) @(posedge clk);
    endtask

    task automatic return_from_irq_instr();
        @(posedge clk);
        retiExec <= 1'b1;
        @(posedge clk);
        retiExec <= 1'b0;
        waitPc(lastPush);
    endtask

    // fetch address at each take must be what is pushed
    always @(posedge clk)
    begin
        if (irqReq === 1'b1 && instrBoundary === 1'b1)
            tkPc <= pcNext;
        if (pushStack === 1'b1)
        begin
            chk({19'h0, pushData}, {19'h0, tkPc});
            lastPush <= pushData;
        end
    end

    // hang guard
    initial
    begin
        #500000;
        errors++;
        wrap_up();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < NUM_REG; k++)
            rd(adrList[k], 32'h0);
        rd(8'h18, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        for (int k = 0; k < 5; k++)
        begin
            wr(adrList[k], 32'hFF);
            rd(adrList[k], {24'h0, maskList[k]});
            wr(adrList[k], 32'h0);
        end
        // flag without enable, then enable without global
        wr(OFS_CTRL1, 32'h10);
        wr(OFS_CTRL0, 32'h01);
        instrBoundary <= 1'b1;
        noTake(10);
        wr(OFS_CTRL0, 32'h00);
        wr(OFS_CTRL1, 32'h11);
        noTake(10);
        instrBoundary <= 1'b0;
        wr(OFS_CTRL1, 32'h00);
        // each internal source: latch, wake, vector, auto clear, return
        lowPower <= 1'b1;
        for (int i = 2; i < NUM_SRC; i++)
        begin
            ra = 8'(SRC_REG[i] * 4);
            fb = 8'(1 << SRC_FBIT[i]);
            eb = 8'(1 << SRC_EBIT[i]);
            pulse(i, 1'b1);
            rd(ra, {24'h0, fb});
            pulse(i, 1'b0);
            wr(ra, {24'h0, fb | eb | ((ra == OFS_CTRL0) ? 8'h01 : 8'h00)});
            if (ra != OFS_CTRL0)
                wr(OFS_CTRL0, 32'h01);
            instrBoundary <= 1'b1;
            waitPc(PC_W'(VEC_BASE + VEC_STEP * i));
            instrBoundary <= 1'b0;
            rd(ra, {24'h0, eb});
            rd(OFS_CTRL0, (ra == OFS_CTRL0) ? {24'h0, eb} : 32'h0);
            return_from_irq_instr();
            wr(ra, 32'h0);
        end
        lowPower <= 1'b0;
        // every edge code on both pins
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_EDGE, 32'(c | (c << 2)));
            pin(1'b1, 1'b1);
            rd(OFS_CTRL0, c[0] ? 32'h30 : 32'h0);
            wr(OFS_CTRL0, 32'h0);
            pin(1'b0, 1'b0);
            rd(OFS_CTRL0, c[1] ? 32'h30 : 32'h0);
            wr(OFS_CTRL0, 32'h0);
        end
        // output direction or other routing sets nothing
        pinADirIn <= 1'b0;
        pinBShareSel <= 1'b0;
        pin(1'b1, 1'b1);
        rd(OFS_CTRL0, 32'h0);
        pinADirIn <= 1'b1;
        pinBShareSel <= 1'b1;
        pinAPullSel <= 1'b1;
        repeat (2) @(posedge clk);
        chk({30'h0, pinAPullEn, pinBPullEn}, 32'h2);
        // both pins pending, then nesting until the stack is full
        wr(OFS_CTRL0, 32'h37);
        instrBoundary <= 1'b1;
        waitPc(VEC_BASE);
        instrBoundary <= 1'b0;
        rd(OFS_CTRL0, 32'h26);
        wr(OFS_CTRL0, 32'h27);
        instrBoundary <= 1'b1;
        waitPc(PC_W'(VEC_BASE + VEC_STEP));
        rd(OFS_STATUS, 32'h12);
        wr(OFS_CTRL0, 32'h4F);
        noTake(10);
        return_from_irq_instr();
        waitPc(PC_W'(VEC_BASE + VEC_STEP * 2));
        wrap_up();
    end
endmodule
